// File: logic/ssao_cfg.svh
// Register offsets, field positions and reset values of the axis outputs.
`ifndef SSAO_CFG_SVH
`define SSAO_CFG_SVH
`define SSAO_OFF_CTRL 8'h00
`define SSAO_OFF_ENA 8'h04
`define SSAO_OFF_REV 8'h08
`define SSAO_OFF_FILT 8'h0C
`define SSAO_OFF_STAT 8'h10
`define SSAO_OFF_AOUT 8'h20
`define SSAO_OFF_RATE 8'h30
`define SSAO_OFF_MOVE 8'h40
`define SSAO_OFF_LEFT 8'h50
`define SSAO_BIT_RUN 4
`define SSAO_BIT_FOFF 5
`define SSAO_BIT_RELAY 6
`define SSAO_BIT_GEN 7
`define SSAO_BIT_DIR 16
`define SSAO_DO_LSB 4
`define SSAO_RST_CTRL 8'h00
`define SSAO_RST_ENA 8'h00
`define SSAO_RST_REV 4'h0
`define SSAO_RST_FILT 4'h4
`endif

// File: logic/ssao_pkg.sv
// Types shared by the axis output stage.
package ssao_pkg;
    // One stepper axis line set, true and negated.
    typedef struct packed {
        logic pulse;
        logic pulse_n;
        logic dir;
        logic dir_n;
    } ssao_step_s;
    // One analog channel value, signed full scale.
    typedef logic signed [15:0] ssao_aout_t;
    // Phases of one step move.
    typedef enum logic [2:0] {
        SSAO_PH_IDLE = 3'b000,
        SSAO_PH_LEAD = 3'b001,
        SSAO_PH_LOW = 3'b010,
        SSAO_PH_HIGH = 3'b011,
        SSAO_PH_TAIL = 3'b100
    } ssao_phase_e;
endpackage

// File: logic/ssao_stepgen.sv
// Step pulse generator for one stepper axis.
`timescale 1ns/10ps
`default_nettype none
module ssao_stepgen
    import ssao_pkg::*;
#(
    parameter int RW = 16,
    parameter int CW = 16
)
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // Move command.
    input wire logic en_in,
    input wire logic load_in,
    input wire logic left_in,
    input wire logic [CW-1:0] count_in,
    input wire logic [RW-1:0] rate_in,
    // Lines and state.
    output var ssao_step_s lines_out,
    output logic busy_out,
    output logic [CW-1:0] remain_out
);
    logic [RW-1:0] acc_r; // Phase accumulator.
    logic [RW:0] sum; // Accumulator sum with carry.
    logic ovf; // One tick of the half step period.
    logic take; // A move command is accepted.
    ssao_phase_e phase_r;
    ssao_phase_e phase_nxt;

    // The carry sets the half-period, so rate scales frequency linearly.
    assign sum = {1'b0, acc_r} + {1'b0, rate_in};
    assign ovf = en_in && sum[RW];
    assign busy_out = (phase_r != SSAO_PH_IDLE);
    assign take = load_in && !busy_out && (count_in != '0);

    // Accumulator restarts at a load so the lead phase is a full half step period.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            acc_r <= '0;
        else if (take)
            acc_r <= '0;
        else if (en_in && busy_out)
            acc_r <= sum[RW-1:0];
    end

    // Phase sequence: lead, pulses, then a quiet tail before the next move.
    always_comb
    begin
        phase_nxt = phase_r;
        case (phase_r)
            SSAO_PH_IDLE: if (take) phase_nxt = SSAO_PH_LEAD;
            SSAO_PH_LEAD: if (ovf) phase_nxt = SSAO_PH_LOW;
            SSAO_PH_LOW: if (ovf) phase_nxt = SSAO_PH_HIGH;
            SSAO_PH_HIGH:
                if (ovf)
                    phase_nxt = (remain_out != '0) ? SSAO_PH_LOW : SSAO_PH_TAIL;
            SSAO_PH_TAIL: if (ovf) phase_nxt = SSAO_PH_IDLE;
            default: phase_nxt = SSAO_PH_IDLE;
        endcase
    end

    // Phase register.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            phase_r <= SSAO_PH_IDLE;
        else
            phase_r <= phase_nxt;
    end

    // Pulses still owed; one is spent at each rising edge.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            remain_out <= '0;
        else if (take)
            remain_out <= count_in;
        else if (ovf && phase_r == SSAO_PH_LOW)
            remain_out <= remain_out - CW'(1);
    end

    // Line pairs always change together, so both halves stay complementary.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            lines_out <= '{pulse: 1'b0, pulse_n: 1'b1, dir: 1'b0, dir_n: 1'b1};
        else if (take)
        begin
            lines_out.dir <= left_in;
            lines_out.dir_n <= ~left_in;
        end
        else if (ovf && phase_r == SSAO_PH_LOW)
        begin
            lines_out.pulse <= 1'b1;
            lines_out.pulse_n <= 1'b0;
        end
        else if (ovf && phase_r == SSAO_PH_HIGH)
        begin
            lines_out.pulse <= 1'b0;
            lines_out.pulse_n <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: logic/ssao_ramp.sv
// Linear interpolation and switchable output filter for one channel.
`timescale 1ns/10ps
`default_nettype none
module ssao_ramp
    import ssao_pkg::*;
#(
    parameter int S = 8
)
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // Servo tick and settings.
    input wire logic tick_in,
    input wire logic filt_off_in,
    input wire logic [3:0] filt_shift_in,
    input wire ssao_aout_t target_in,
    // Channel value.
    output ssao_aout_t value_out
);
    ssao_aout_t last_r; // Target of the last servo tick.
    logic signed [16:0] incr_r; // Per-cycle slope in fractional units.
    logic signed [16+S:0] interp_r; // Interpolated value with S fraction bits.
    logic signed [16+S:0] fy_r; // Filter state, same scale.
    logic signed [16+S:0] fdiff;

    assign fdiff = interp_r - fy_r;

    // A tick period is 2**S cycles, so adding the raw difference each cycle
    // lands exactly on the new target with no divider.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            last_r <= '0;
            incr_r <= '0;
            interp_r <= '0;
        end
        else
        begin
            interp_r <= interp_r + {{S{incr_r[16]}}, incr_r};
            if (tick_in)
            begin
                last_r <= target_in;
                incr_r <= {target_in[15], target_in} - {last_r[15], last_r};
            end
        end
    end

    // First-order low pass; shift sets the filter time.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            fy_r <= '0;
        else
            fy_r <= fy_r + (fdiff >>> filt_shift_in);
    end

    // Output register picks filtered or plain interpolated value.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            value_out <= '0;
        else if (filt_off_in)
            value_out <= interp_r[15+S:S];
        else
            value_out <= fy_r[15+S:S];
    end
endmodule
`default_nettype wire

// File: logic/ssao_axes.sv
// Four-axis drive output stage: setpoints, step lines, enables, contacts.
//
// Notes on behaviour
// - Four axes, each analog or stepper, mixed.
// - One drive enable output per axis.
// - Analog axis: bipolar speed setpoint plus enable.
// - Contact closes once program enables the axis; here a stepper axis contact also waits for run.
// - Stepper lines come as true/negated pairs.
// - Pulse count equals commanded travel.
// - Pulse rate proportional to commanded speed.
// - Direction high means left, low right.
// - Per-axis reversal inverts direction mapping.
// - Stepper enable needs axis enable and run.
// - Stepper enable and contact switch together.
// - Extended: channels as general filtered analog outputs.
// - Filter on by default, in every use.
// - Outputs interpolate linearly across servo cycles.
// - Extended: contacts usable as digital outputs.
//
// Added by the designer: the register offsets and the plain strobed port.
`include "ssao_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module ssao_axes
    import ssao_pkg::*;
#(
    parameter bit EXTENDED = 1'b1,
    parameter int SERVO_SHIFT = 8,
    parameter int RW = 16,
    parameter int CW = 16
)
(
    // Clock and reset.
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    // Register port.
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WSTB_IN,
    input wire logic REG_RSTB_IN,
    output logic [31:0] REG_RDATA_OUT,
    // Analog channels.
    output wire ssao_aout_t [3:0] SPEED_SETPOINT_OUT,
    // Enables and contacts.
    output logic [3:0] CONTROLLER_RELEASE_CONTACT_OUT,
    output logic [3:0] DRIVE_RELEASE_SIGNAL_OUT,
    output logic [3:0] DRIVE_RELEASE_SIGNAL_N_OUT,
    // Stepper lines.
    output wire ssao_step_s [3:0] STEP_PULSE_LINE_OUT
);
    logic [7:0] ctrl_r; // Stepper select, run, filter off, relay, general.
    logic [7:0] ena_r; // Axis enables and digital output bits.
    logic [3:0] rev_r; // Direction reversal per axis.
    logic [3:0] filt_r; // Filter time as a shift.
    logic [3:0][15:0] aout_r; // Setpoint or general output values.
    logic [3:0][RW-1:0] rate_r; // Step rates.
    logic [SERVO_SHIFT-1:0] servo_cnt_r; // Servo cycle divider.
    logic servo_tick; // One-cycle servo cycle enable.
    logic [3:0] ax_en; // Effective axis enable.
    logic [3:0] contact_nxt;
    logic [3:0] mv_load; // Move write per axis.
    logic [3:0] busy_w; // Axis still stepping.
    logic [3:0][CW-1:0] remain_w; // Pulses still owed.
    logic [1:0] rch; // Channel from the address.
    logic [31:0] rd_nxt;
    logic relay_mode; // Contacts serve as digital outputs.
    logic gen_mode; // Channels serve as general analog outputs.

    // Block decode: the upper nibble picks a four-word block.
    function automatic logic blk_hit(input logic [7:0] a, input logic [7:0] b);
        return (a[7:4] == b[7:4]) && (a[1:0] == 2'b00);
    endfunction

    // Single-register decode.
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    assign rch = REG_ADDR_IN[3:2];
    // The variant modes do not exist on the basic part.
    assign relay_mode = EXTENDED && ctrl_r[`SSAO_BIT_RELAY];
    assign gen_mode = EXTENDED && ctrl_r[`SSAO_BIT_GEN];

    // Mode and control register.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            ctrl_r <= `SSAO_RST_CTRL;
        else if (REG_WSTB_IN && reg_hit(REG_ADDR_IN, `SSAO_OFF_CTRL))
            ctrl_r <= REG_WDATA_IN[7:0];
    end

    // Axis enables set by the user program, plus digital output bits.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            ena_r <= `SSAO_RST_ENA;
        else if (REG_WSTB_IN && reg_hit(REG_ADDR_IN, `SSAO_OFF_ENA))
            ena_r <= REG_WDATA_IN[7:0];
    end

    // Reversal and filter time settings.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            rev_r <= `SSAO_RST_REV;
            filt_r <= `SSAO_RST_FILT;
        end
        else if (REG_WSTB_IN && reg_hit(REG_ADDR_IN, `SSAO_OFF_REV))
            rev_r <= REG_WDATA_IN[3:0];
        else if (REG_WSTB_IN && reg_hit(REG_ADDR_IN, `SSAO_OFF_FILT))
            filt_r <= REG_WDATA_IN[3:0];
    end

    // Channel values and step rates, one word per axis.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            aout_r <= '0;
            rate_r <= '0;
        end
        else if (REG_WSTB_IN && blk_hit(REG_ADDR_IN, `SSAO_OFF_AOUT))
            aout_r[rch] <= REG_WDATA_IN[15:0];
        else if (REG_WSTB_IN && blk_hit(REG_ADDR_IN, `SSAO_OFF_RATE))
            rate_r[rch] <= REG_WDATA_IN[RW-1:0];
    end

    // A move word starts a stepper move; it is dropped while busy so the
    // direction never changes inside a move.
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            mv_load[i] = REG_WSTB_IN && blk_hit(REG_ADDR_IN, `SSAO_OFF_MOVE)
                && (rch == 2'(i)) && ctrl_r[i];
    end

    // Servo cycle divider; its period is 2**SERVO_SHIFT clocks.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            servo_cnt_r <= '0;
        else
            servo_cnt_r <= servo_cnt_r + SERVO_SHIFT'(1);
    end
    assign servo_tick = &servo_cnt_r;

    // Stepper axes only enable while running; analog contacts follow the
    // program directly.
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            ax_en[i] = ena_r[i] && (!ctrl_r[i] || ctrl_r[`SSAO_BIT_RUN]);
            if (relay_mode)
                contact_nxt[i] = ena_r[`SSAO_DO_LSB + i];
            else
                contact_nxt[i] = ax_en[i];
        end
    end

    // Contact and drive enables share one register stage, so they switch
    // in the same cycle.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            CONTROLLER_RELEASE_CONTACT_OUT <= '0;
            DRIVE_RELEASE_SIGNAL_OUT <= '0;
            DRIVE_RELEASE_SIGNAL_N_OUT <= '1;
        end
        else
        begin
            CONTROLLER_RELEASE_CONTACT_OUT <= contact_nxt;
            DRIVE_RELEASE_SIGNAL_OUT <= ax_en & ctrl_r[3:0];
            DRIVE_RELEASE_SIGNAL_N_OUT <= ~(ax_en & ctrl_r[3:0]);
        end
    end

    // Per-axis channel and step generator.
    for (genvar g = 0; g < 4; g++)
    begin : gen_ax
        ssao_aout_t tgt; // Stepper axes hold zero unless in general mode.
        assign tgt = (gen_mode || !ctrl_r[g]) ? aout_r[g] : '0;
        ssao_ramp #(.S(SERVO_SHIFT)) u_ramp (
            .clk_in(MCLK_IN),
            .rst_in(SYS_RST_IN),
            .tick_in(servo_tick),
            .filt_off_in(EXTENDED && ctrl_r[`SSAO_BIT_FOFF]),
            .filt_shift_in(filt_r),
            .target_in(tgt),
            .value_out(SPEED_SETPOINT_OUT[g])
        );
        ssao_stepgen #(.RW(RW), .CW(CW)) u_step (
            .clk_in(MCLK_IN),
            .rst_in(SYS_RST_IN),
            .en_in(ax_en[g] && ctrl_r[g]),
            .load_in(mv_load[g]),
            .left_in(REG_WDATA_IN[`SSAO_BIT_DIR] ^ rev_r[g]),
            .count_in(REG_WDATA_IN[CW-1:0]),
            .rate_in(rate_r[g]),
            .lines_out(STEP_PULSE_LINE_OUT[g]),
            .busy_out(busy_w[g]),
            .remain_out(remain_w[g])
        );
    end

    // Read multiplexer; unmapped addresses and the move block read zero.
    always_comb
    begin
        rd_nxt = '0;
        if (reg_hit(REG_ADDR_IN, `SSAO_OFF_CTRL))
            rd_nxt[7:0] = ctrl_r;
        else if (reg_hit(REG_ADDR_IN, `SSAO_OFF_ENA))
            rd_nxt[7:0] = ena_r;
        else if (reg_hit(REG_ADDR_IN, `SSAO_OFF_REV))
            rd_nxt[3:0] = rev_r;
        else if (reg_hit(REG_ADDR_IN, `SSAO_OFF_FILT))
            rd_nxt[3:0] = filt_r;
        else if (reg_hit(REG_ADDR_IN, `SSAO_OFF_STAT))
            rd_nxt[11:0] = {CONTROLLER_RELEASE_CONTACT_OUT,
                DRIVE_RELEASE_SIGNAL_OUT, busy_w};
        else if (blk_hit(REG_ADDR_IN, `SSAO_OFF_AOUT))
            rd_nxt[15:0] = aout_r[rch];
        else if (blk_hit(REG_ADDR_IN, `SSAO_OFF_RATE))
            rd_nxt[RW-1:0] = rate_r[rch];
        else if (blk_hit(REG_ADDR_IN, `SSAO_OFF_LEFT))
            rd_nxt[CW-1:0] = remain_w[rch];
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            REG_RDATA_OUT <= '0;
        else if (REG_RSTB_IN)
            REG_RDATA_OUT <= rd_nxt;
        else
            REG_RDATA_OUT <= '0;
    end

    // Checks on axis 0, plus the enable pair on all axes; all axes share the same logic.
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    sequence s_rise;
        $rose(STEP_PULSE_LINE_OUT[0].pulse);
    endsequence
    sequence s_dir_quiet;
        $stable(STEP_PULSE_LINE_OUT[0].dir) [*2];
    endsequence
    sequence s_no_rise;
        !$rose(STEP_PULSE_LINE_OUT[0].pulse) ##1
            !$rose(STEP_PULSE_LINE_OUT[0].pulse);
    endsequence

    chk_pair_enable: assert property (
        DRIVE_RELEASE_SIGNAL_N_OUT == ~DRIVE_RELEASE_SIGNAL_OUT)
        else $error("Enable pair is not complementary.");
    chk_pair_lines: assert property (
        STEP_PULSE_LINE_OUT[0].pulse_n == !STEP_PULSE_LINE_OUT[0].pulse
        && STEP_PULSE_LINE_OUT[0].dir_n == !STEP_PULSE_LINE_OUT[0].dir)
        else $error("Step line pair is not complementary.");
    chk_run_gate: assert property (
        DRIVE_RELEASE_SIGNAL_OUT[0] |->
            $past(ena_r[0] && ctrl_r[0] && ctrl_r[`SSAO_BIT_RUN]))
        else $error("Stepper enable without axis enable and run.");
    chk_same_cycle: assert property (
        $past(ctrl_r[0] && !relay_mode) |->
            CONTROLLER_RELEASE_CONTACT_OUT[0] == DRIVE_RELEASE_SIGNAL_OUT[0])
        else $error("Contact and stepper enable differ.");
    chk_contact_fast: assert property (
        (ena_r[0] && !ctrl_r[0] && !relay_mode) |=>
            CONTROLLER_RELEASE_CONTACT_OUT[0])
        else $error("Contact not closed one cycle after enable.");
    chk_idle_disabled: assert property (
        !DRIVE_RELEASE_SIGNAL_OUT[0] |-> $stable(STEP_PULSE_LINE_OUT[0].pulse))
        else $error("Step edge while enable is off.");
    chk_dir_hold: assert property (
        s_rise |=> s_dir_quiet)
        else $error("Direction changed right after a step.");
    chk_dir_lead: assert property (
        $changed(STEP_PULSE_LINE_OUT[0].dir) |-> s_no_rise)
        else $error("Step too soon after a direction change.");
    chk_count_step: assert property (
        s_rise |-> remain_w[0] == $past(remain_w[0]) - CW'(1))
        else $error("Step count not spent by one per rising edge.");
    chk_dir_map: assert property (
        (mv_load[0] && !busy_w[0] && REG_WDATA_IN[CW-1:0] != '0) |=>
            STEP_PULSE_LINE_OUT[0].dir ==
            $past(REG_WDATA_IN[`SSAO_BIT_DIR] ^ rev_r[0]))
        else $error("Direction line does not follow command and reversal.");
endmodule
`default_nettype wire

// File: test/ssao_step_unit.sv
// Stepper power unit model that counts steps taken on one axis.
`timescale 1ns/10ps
`default_nettype none
module ssao_step_unit
    import ssao_pkg::*;
(
    // Clock and axis lines.
    input wire logic clk_in,
    input wire ssao_step_s lines_in,
    input wire logic ena_in,
    input wire logic ena_n_in,
    // What the unit saw.
    output var int steps_out,
    output var int period_out,
    output var int stray_out,
    output var int pair_err_out
);
    logic pulse_q = 1'b0; // Previous pulse level.
    logic dir_q = 1'b0; // Previous direction level.
    int cyc = 0; // Free-running cycle count.
    int last_rise = 0; // Cycle of the previous rising edge.
    initial
    begin
        steps_out = 0;
        period_out = 0;
        stray_out = 0;
        pair_err_out = 0;
    end
    // Inputs are sampled on the clock, as an opto-coupled input would be.
    always @(posedge clk_in)
    begin
        cyc = cyc + 1;
        // The pulse line pair and the enable pair must stay complementary.
        // Lines that are not yet driven before the first reset edge are
        // not counted, so the check only judges settled levels.
        if (lines_in.pulse_n !== ~lines_in.pulse
            || ena_n_in !== ~ena_in)
            pair_err_out++;
        if (lines_in.pulse === 1'b1 && pulse_q === 1'b0)
        begin
            // A step taken with a moving direction line is a fault.
            if (lines_in.dir !== dir_q)
                pair_err_out++;
            // One step per rising edge, and only while enabled.
            if (ena_in === 1'b1)
            begin
                steps_out++;
                period_out = cyc - last_rise;
                last_rise = cyc;
            end
            else
                stray_out++;
        end
        pulse_q = lines_in.pulse;
        dir_q = lines_in.dir;
    end
endmodule
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the four-axis drive output stage.
`include "ssao_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
    import ssao_pkg::*;
    logic clk; // Bench clock.
    logic rst; // Bench reset.
    logic [7:0] addr; // Register address.
    logic [31:0] wdata; // Register write data.
    logic wstb; // Write strobe.
    logic rstb; // Read strobe.
    wire logic [31:0] rdata; // Register read data.
    wire ssao_aout_t [3:0] aval; // Analog channel values.
    wire logic [3:0] contact; // Release contacts.
    wire logic [3:0] drv; // Drive enables, true.
    wire logic [3:0] drv_n; // Drive enables, negated.
    wire ssao_step_s [3:0] lines; // Stepper lines.
    int steps, period, stray, pair_err; // Partner observations.
    int fail_count = 0; // Mismatches seen.
    int checks_done = 0; // Comparisons made.
    int mid; // Samples caught part way along a ramp.
    int s0; // Step count before a pause.
    logic [31:0] rd; // Last read result.

    // A short servo period keeps the analog scenarios brief.
    ssao_axes #(.SERVO_SHIFT(4)) uut (.MCLK_IN(clk), .SYS_RST_IN(rst),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WSTB_IN(wstb),
        .REG_RSTB_IN(rstb), .REG_RDATA_OUT(rdata),
        .SPEED_SETPOINT_OUT(aval), .CONTROLLER_RELEASE_CONTACT_OUT(contact),
        .DRIVE_RELEASE_SIGNAL_OUT(drv), .DRIVE_RELEASE_SIGNAL_N_OUT(drv_n),
        .STEP_PULSE_LINE_OUT(lines));

    // Power unit on axis 0.
    ssao_step_unit unit0 (.clk_in(clk), .lines_in(lines[0]),
        .ena_in(drv[0]), .ena_n_in(drv_n[0]), .steps_out(steps),
        .period_out(period), .stray_out(stray), .pair_err_out(pair_err));

    // Free-running 100 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Compare and report.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One-cycle register write.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wstb <= 1'b1;
        @(posedge clk);
        wstb <= 1'b0;
    endtask

    // One-cycle register read; data is taken in the following cycle.
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rstb <= 1'b1;
        @(posedge clk);
        rstb <= 1'b0;
        #1;
        rd = rdata;
    endtask

    // Let n edges pass, then step clear of the edge.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Poll the busy bit of one axis with a bounded count.
    task automatic wait_idle(input int ax);
        int n;
        n = 0;
        rdr(`SSAO_OFF_STAT);
        while (rd[ax] !== 1'b0 && n < 500)
        begin
            rdr(`SSAO_OFF_STAT);
            n++;
        end
        check(rd[ax], 1'b0);
    endtask

    // Verdict; also reached by the watchdog.
    task automatic conclude;
        if (fail_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // The whole run needs under a thousand cycles; the 10000-cycle limit is ample margin.
    initial
    begin
        #100000;
        fail_count++;
        conclude();
    end

    // Main sequence.
    initial
    begin
        rst = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        wstb = 1'b0;
        rstb = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        // Quiet levels out of reset.
        check(drv_n, 4'hF);
        check(lines[0], 4'h5);
        check(contact, 4'h0);
        rdr(`SSAO_OFF_FILT);
        check(rd, 32'h4);
        rdr(`SSAO_OFF_CTRL);
        check(rd, 32'h0);
        rdr(8'h14);
        check(rd, 32'h0);
        // Axis 0 stepper, axis 1 analog, enabled but not running.
        wr(`SSAO_OFF_CTRL, 32'h01);
        wr(`SSAO_OFF_ENA, 32'h3);
        tick(3);
        check(drv, 4'h0);
        check(contact, 4'h2);
        // Run mode: stepper enable and its contact come on together.
        wr(`SSAO_OFF_CTRL, 32'h11);
        tick(3);
        check(drv, 4'h1);
        check(contact, 4'h3);
        check(drv_n, 4'hE);
        // Three steps to the left, one step every four clocks.
        wr(`SSAO_OFF_RATE, 32'h8000);
        wr(`SSAO_OFF_MOVE, 32'h10003);
        tick(2);
        check(lines[0].dir, 1'b1);
        wait_idle(0);
        check(steps, 3);
        check(period, 4);
        rdr(`SSAO_OFF_LEFT);
        check(rd, 32'h0);
        // Reversed axis: a move to the right drives the line high.
        wr(`SSAO_OFF_REV, 32'h1);
        wr(`SSAO_OFF_MOVE, 32'h00002);
        tick(2);
        check(lines[0].dir, 1'b1);
        wait_idle(0);
        // Half the rate doubles the step period.
        wr(`SSAO_OFF_REV, 32'h0);
        wr(`SSAO_OFF_RATE, 32'h4000);
        wr(`SSAO_OFF_MOVE, 32'h00002);
        tick(2);
        check(lines[0].dir, 1'b0);
        wait_idle(0);
        check(steps, 7);
        check(period, 8);
        // Zero count and a move on an analog axis are both refused.
        wr(`SSAO_OFF_MOVE, 32'h0);
        wr(`SSAO_OFF_MOVE + 8'h04, 32'h5);
        rdr(`SSAO_OFF_STAT);
        check(rd, 32'h310);
        // Enable dropped mid-move: no edges until it returns.
        wr(`SSAO_OFF_RATE, 32'h1000);
        wr(`SSAO_OFF_MOVE, 32'h4);
        tick(40);
        wr(`SSAO_OFF_ENA, 32'h2);
        tick(3);
        s0 = steps;
        check(drv[0], 1'b0);
        tick(100);
        check(steps, s0);
        check(stray, 0);
        wr(`SSAO_OFF_ENA, 32'h3);
        wait_idle(0);
        check(steps, 11);
        check(pair_err, 0);
        // Slowest filter barely moves toward a new target.
        wr(`SSAO_OFF_FILT, 32'hF);
        wr(`SSAO_OFF_AOUT + 8'h04, 32'hF000);
        tick(96);
        check(aval[1] === 16'hF000, 1'b0);
        // Filter off, channels general: ramps land on their targets.
        wr(`SSAO_OFF_CTRL, 32'hB1);
        wr(`SSAO_OFF_AOUT, 32'h0200);
        wr(`SSAO_OFF_AOUT + 8'h04, 32'h1000);
        mid = 0;
        repeat (96)
        begin
            tick(1);
            if (aval[1] > 16'sh0000 && aval[1] < 16'sh1000)
                mid++;
        end
        check(mid != 0, 1'b1);
        check(aval[1], 32'h1000);
        check(aval[0], 32'h0200);
        // Both axes analog: contacts follow the enables without run.
        wr(`SSAO_OFF_CTRL, 32'h00);
        tick(3);
        check(contact, 4'h3);
        check(drv, 4'h0);
        // Contacts as plain digital outputs.
        wr(`SSAO_OFF_CTRL, 32'h50);
        wr(`SSAO_OFF_ENA, 32'hA0);
        tick(3);
        check(contact, 4'hA);
        check(drv, 4'h0);
        conclude();
    end
endmodule
`default_nettype wire
